/* File: design/uvra_defines.svh */
// Purpose: Constants for the vendor request register access block.
// Assumes: Included by bare name from the baud generator, port register and request decoder files.
// Notes: Offsets, codes, reset values and sizes of the design live here; the monitor and bench repeat some as literals.
`ifndef UVRA_DEFINES_SVH
`define UVRA_DEFINES_SVH

`define UVRA_TYPE_READ 8'hC0
`define UVRA_TYPE_WRITE 8'h40
`define UVRA_REQ_READ 8'h0D
`define UVRA_REQ_WRITE 8'h0E

`define UVRA_TGT_GLOBAL 8'h00
`define UVRA_TGT_PORT1 8'h01
`define UVRA_TGT_PORT2 8'h03
`define UVRA_TGT_EEPROM 8'h09

`define UVRA_PORT_LENGTH 16'h0001

`define UVRA_OFS_DATA 3'h0
`define UVRA_OFS_IER 3'h1
`define UVRA_OFS_FIFO 3'h2
`define UVRA_OFS_LCR 3'h3
`define UVRA_OFS_MCR 3'h4
`define UVRA_OFS_LSR 3'h5
`define UVRA_OFS_MSR 3'h6
`define UVRA_OFS_SCRATCH 3'h7

`define UVRA_LCR_DLAB 7
`define UVRA_MCR_DTR 0
`define UVRA_SCR_485_EN 7
`define UVRA_SCR_485_POL 6
`define UVRA_DCFG1_INTR_LEN 6

`define UVRA_GLB_DEVCFG1 3'h1

`define UVRA_RST_DIV_LOW 8'h01
`define UVRA_RST_DIV_HIGH 8'h00
`define UVRA_RST_REG 8'h00

`define UVRA_OVERSAMPLE 5'h10
`define UVRA_DIV_HIGH_WEIGHT 17'h0_0100

`define UVRA_EP0_SIZE_FS 10'h008
`define UVRA_EP0_SIZE_HS 10'h040
`define UVRA_BULK_SIZE_FS 10'h040
`define UVRA_BULK_SIZE_HS 10'h200
`define UVRA_INTR_LEN_SHORT 4'h5
`define UVRA_INTR_LEN_LONG 4'hD

`endif

/* File: design/uvra_pkg.sv */
// Purpose: Types shared by the vendor request register access block.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only; numbers sit in the defines header.
package uvra_pkg;

    typedef enum logic [1:0] {
        UVRA_IDLE,
        UVRA_EE_WAIT,
        UVRA_ANSWER
    } uvra_state_t;

    typedef logic [7:0] uvra_byte_t;

endpackage : uvra_pkg

/* File: design/uvra_reg_if.sv */
// Purpose: Register access carrier from the request decoder to one port.
// Assumes: One clock domain shared by both ends.
// Notes: Strobes last one cycle; read data is combinational.
`timescale 1ns/100ps
interface uvra_reg_if;
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport master (
        output wr,
        output rd,
        output addr,
        output wdata,
        input rdata
    );

    modport slave (
        input wr,
        input rd,
        input addr,
        input wdata,
        output rdata
    );
endinterface : uvra_reg_if

/* File: design/uvra_baud_gen.sv */
// Purpose: Baud timing from a sixteen bit divisor.
// Assumes: Divisor changes only between characters.
// Notes: A divisor of zero stops both ticks rather than wrapping.
`include "uvra_defines.svh"
`timescale 1ns/100ps
module uvra_baud_gen
    import uvra_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [15:0] divisor,
    output logic tick16,
    output logic bit_tick
);
    logic [15:0] div_count;
    logic [3:0] over_count;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            div_count <= 16'h0000;
            tick16 <= 1'b0;
        end else if (divisor == 16'h0000) begin
            div_count <= 16'h0000;
            tick16 <= 1'b0;
        end else if (div_count >= divisor - 16'h0001) begin
            div_count <= 16'h0000;
            tick16 <= 1'b1;
        end else begin
            div_count <= div_count + 16'h0001;
            tick16 <= 1'b0;
        end
    end

    // One bit lasts sixteen oversample ticks.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            over_count <= 4'h0;
            bit_tick <= 1'b0;
        end else if (tick16) begin
            over_count <= over_count + 4'h1;
            bit_tick <= (over_count == 4'(`UVRA_OVERSAMPLE - 5'h01));
        end else begin
            bit_tick <= 1'b0;
        end
    end
endmodule : uvra_baud_gen

/* File: design/uvra_port_regs.sv */
// Purpose: Register file and line control of one serial port.
// Assumes: Receive data, status and transmitter activity come from the UART.
// Notes: Status registers at offsets 5 and 6 ignore writes.
`include "uvra_defines.svh"
`timescale 1ns/100ps
module uvra_port_regs
    import uvra_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    uvra_reg_if.slave bus,
    input wire logic [7:0] rx_data,
    input wire logic [7:0] iir_status,
    input wire logic [7:0] lsr_status,
    input wire logic [7:0] msr_status,
    input wire logic tx_active,
    output logic tx_load,
    output logic [7:0] tx_data,
    output logic fifo_ctl_load,
    output logic [7:0] fifo_ctl,
    output logic rx_pop,
    output logic dtr_n,
    output logic tick16,
    output logic bit_tick
);
    uvra_byte_t divisor_low_byte;
    uvra_byte_t divisor_high_byte;
    uvra_byte_t interrupt_enable_reg;
    uvra_byte_t line_control_reg;
    uvra_byte_t modem_control_reg;
    uvra_byte_t scratch_reg;
    logic dlab;
    logic [16:0] divisor_full;

    assign dlab = line_control_reg[`UVRA_LCR_DLAB];
    assign divisor_full = `UVRA_DIV_HIGH_WEIGHT * {9'h000, divisor_high_byte}
        + {9'h000, divisor_low_byte};

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            divisor_low_byte <= `UVRA_RST_DIV_LOW;
            divisor_high_byte <= `UVRA_RST_DIV_HIGH;
            interrupt_enable_reg <= `UVRA_RST_REG;
            line_control_reg <= `UVRA_RST_REG;
            modem_control_reg <= `UVRA_RST_REG;
            scratch_reg <= `UVRA_RST_REG;
        end else if (bus.wr) begin
            case (bus.addr)
                `UVRA_OFS_DATA: begin
                    if (dlab) begin
                        divisor_low_byte <= bus.wdata;
                    end
                end
                `UVRA_OFS_IER: begin
                    if (dlab) begin
                        divisor_high_byte <= bus.wdata;
                    end else begin
                        interrupt_enable_reg <= bus.wdata;
                    end
                end
                `UVRA_OFS_LCR: line_control_reg <= bus.wdata;
                `UVRA_OFS_MCR: modem_control_reg <= bus.wdata;
                `UVRA_OFS_SCRATCH: scratch_reg <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Holding and FIFO writes leave as one cycle strobes with registered data.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_load <= 1'b0;
            tx_data <= 8'h00;
            fifo_ctl_load <= 1'b0;
            fifo_ctl <= 8'h00;
            rx_pop <= 1'b0;
        end else begin
            tx_load <= bus.wr && bus.addr == `UVRA_OFS_DATA && !dlab;
            fifo_ctl_load <= bus.wr && bus.addr == `UVRA_OFS_FIFO;
            rx_pop <= bus.rd && bus.addr == `UVRA_OFS_DATA && !dlab;
            if (bus.wr && bus.addr == `UVRA_OFS_DATA && !dlab) begin
                tx_data <= bus.wdata;
            end
            if (bus.wr && bus.addr == `UVRA_OFS_FIFO) begin
                fifo_ctl <= bus.wdata;
            end
        end
    end

    always_comb begin
        case (bus.addr)
            `UVRA_OFS_DATA: bus.rdata = dlab ? divisor_low_byte : rx_data;
            `UVRA_OFS_IER:
                bus.rdata = dlab ? divisor_high_byte : interrupt_enable_reg;
            `UVRA_OFS_FIFO: bus.rdata = iir_status;
            `UVRA_OFS_LCR: bus.rdata = line_control_reg;
            `UVRA_OFS_MCR: bus.rdata = modem_control_reg;
            `UVRA_OFS_LSR: bus.rdata = lsr_status;
            `UVRA_OFS_MSR: bus.rdata = msr_status;
            default: bus.rdata = scratch_reg;
        endcase
    end

    // RS-422 needs no direction control, so it uses the plain modem setting.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dtr_n <= 1'b1;
        end else if (!scratch_reg[`UVRA_SCR_485_EN]) begin
            dtr_n <= !modem_control_reg[`UVRA_MCR_DTR];
        end else if (scratch_reg[`UVRA_SCR_485_POL]) begin
            dtr_n <= tx_active;
        end else begin
            dtr_n <= !tx_active;
        end
    end

    uvra_baud_gen baud (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .divisor(divisor_full[15:0]),
        .tick16(tick16),
        .bit_tick(bit_tick)
    );
endmodule : uvra_port_regs

/* File: design/uvra_vendor_access.sv */
// Purpose: Decode vendor setup requests into register accesses.
// Assumes: The USB core hands over each setup packet as one strobe.
// Notes: Unsupported requests are answered with a stall.
`include "uvra_defines.svh"
`timescale 1ns/100ps
module uvra_vendor_access
    import uvra_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic setup_valid,
    input wire logic [7:0] setup_type,
    input wire logic [7:0] setup_request,
    input wire logic [15:0] setup_value,
    input wire logic [15:0] setup_index,
    input wire logic [15:0] setup_length,
    output logic setup_ready,
    output logic resp_valid,
    output logic resp_stall,
    output logic [7:0] resp_data,
    input wire logic high_speed,
    output logic [9:0] ep0_max_size,
    output logic [9:0] bulk_max_size,
    output logic [3:0] intr_report_len,
    output logic ee_req,
    output logic ee_write,
    output logic [7:0] ee_addr,
    output logic [7:0] ee_wdata,
    input wire logic ee_done,
    input wire logic [7:0] ee_rdata,
    input wire logic [15:0] p_rx_data,
    input wire logic [15:0] p_iir_status,
    input wire logic [15:0] p_lsr_status,
    input wire logic [15:0] p_msr_status,
    input wire logic [1:0] p_tx_active,
    output logic [1:0] p_tx_load,
    output logic [15:0] p_tx_data,
    output logic [1:0] p_fifo_ctl_load,
    output logic [15:0] p_fifo_ctl,
    output logic [1:0] p_rx_pop,
    output logic [1:0] p_dtr_n,
    output logic [1:0] p_tick16,
    output logic [1:0] p_bit_tick,
    output logic [7:0] global_ctl_0,
    output logic [7:0] global_ctl_1
);
    uvra_state_t state;
    uvra_state_t next_state;
    uvra_byte_t global_regs [8];
    logic is_read;
    logic is_write;
    logic [7:0] target;
    logic [2:0] offset;
    logic offset_ok;
    logic len_ok;
    logic take;
    logic to_port1;
    logic to_port2;
    logic to_global;
    logic to_eeprom;
    logic bad;
    logic [7:0] port_rdata [2];

    uvra_reg_if port_bus [2] ();

    assign is_read = setup_type == `UVRA_TYPE_READ
        && setup_request == `UVRA_REQ_READ;
    assign is_write = setup_type == `UVRA_TYPE_WRITE
        && setup_request == `UVRA_REQ_WRITE;
    assign target = setup_value[15:8];
    assign offset = setup_index[2:0];
    assign offset_ok = setup_index[7:3] == 5'h00;
    assign len_ok = setup_length == `UVRA_PORT_LENGTH;
    assign take = setup_valid && state == UVRA_IDLE;
    assign setup_ready = state == UVRA_IDLE;
    assign to_port1 = target == `UVRA_TGT_PORT1;
    assign to_port2 = target == `UVRA_TGT_PORT2;
    assign to_global = target == `UVRA_TGT_GLOBAL;
    assign to_eeprom = target == `UVRA_TGT_EEPROM;
    assign bad = !(is_read || is_write) || !len_ok
        || !(to_port1 || to_port2 || to_global || to_eeprom)
        || (!to_eeprom && !offset_ok);

    // A refused request never strobes any register.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_port
            logic hit;
            assign hit = take && !bad && (g == 0 ? to_port1 : to_port2);
            assign port_bus[g].wr = hit && is_write;
            assign port_bus[g].rd = hit && is_read;
            assign port_bus[g].addr = offset;
            assign port_bus[g].wdata = setup_value[7:0];
            assign port_rdata[g] = port_bus[g].rdata;

            uvra_port_regs port (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .bus(port_bus[g]),
                .rx_data(p_rx_data[8*g +: 8]),
                .iir_status(p_iir_status[8*g +: 8]),
                .lsr_status(p_lsr_status[8*g +: 8]),
                .msr_status(p_msr_status[8*g +: 8]),
                .tx_active(p_tx_active[g]),
                .tx_load(p_tx_load[g]),
                .tx_data(p_tx_data[8*g +: 8]),
                .fifo_ctl_load(p_fifo_ctl_load[g]),
                .fifo_ctl(p_fifo_ctl[8*g +: 8]),
                .rx_pop(p_rx_pop[g]),
                .dtr_n(p_dtr_n[g]),
                .tick16(p_tick16[g]),
                .bit_tick(p_bit_tick[g])
            );
        end
    endgenerate

    // Global control bytes are plain storage; bytes 0 and 1 leave the block and byte 1 also sets the report length.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) begin
                global_regs[i] <= `UVRA_RST_REG;
            end
        end else if (take && !bad && to_global && is_write) begin
            global_regs[offset] <= setup_value[7:0];
        end
    end

    assign global_ctl_0 = global_regs[0];
    assign global_ctl_1 = global_regs[`UVRA_GLB_DEVCFG1];

    always_comb begin
        next_state = state;
        case (state)
            UVRA_IDLE: begin
                if (take && !bad && to_eeprom) begin
                    next_state = UVRA_EE_WAIT;
                end else if (take) begin
                    next_state = UVRA_ANSWER;
                end
            end
            UVRA_EE_WAIT: begin
                if (ee_done) begin
                    next_state = UVRA_ANSWER;
                end
            end
            UVRA_ANSWER: next_state = UVRA_IDLE;
            default: next_state = UVRA_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= UVRA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The EEPROM request holds until the memory controller reports done.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ee_req <= 1'b0;
            ee_write <= 1'b0;
            ee_addr <= 8'h00;
            ee_wdata <= 8'h00;
        end else if (take && !bad && to_eeprom) begin
            ee_req <= 1'b1;
            ee_write <= is_write;
            ee_addr <= setup_index[7:0];
            ee_wdata <= setup_value[7:0];
        end else if (ee_done) begin
            ee_req <= 1'b0;
        end
    end

    // Answer one cycle after the request, or one after the EEPROM finishes.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            resp_valid <= 1'b0;
            resp_stall <= 1'b0;
            resp_data <= 8'h00;
        end else if (take && (bad || !to_eeprom)) begin
            resp_valid <= 1'b1;
            resp_stall <= bad;
            if (bad || is_write) begin
                resp_data <= 8'h00;
            end else if (to_port1) begin
                resp_data <= port_rdata[0];
            end else if (to_port2) begin
                resp_data <= port_rdata[1];
            end else begin
                resp_data <= global_regs[offset];
            end
        end else if (state == UVRA_EE_WAIT && ee_done) begin
            resp_valid <= 1'b1;
            resp_stall <= 1'b0;
            resp_data <= ee_write ? 8'h00 : ee_rdata;
        end else begin
            resp_valid <= 1'b0;
            resp_stall <= 1'b0;
        end
    end

    // Endpoint sizes follow the bus speed; the report length follows config.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ep0_max_size <= `UVRA_EP0_SIZE_FS;
            bulk_max_size <= `UVRA_BULK_SIZE_FS;
            intr_report_len <= `UVRA_INTR_LEN_SHORT;
        end else begin
            ep0_max_size <= high_speed ? `UVRA_EP0_SIZE_HS
                : `UVRA_EP0_SIZE_FS;
            bulk_max_size <= high_speed ? `UVRA_BULK_SIZE_HS
                : `UVRA_BULK_SIZE_FS;
            intr_report_len
                <= global_regs[`UVRA_GLB_DEVCFG1][`UVRA_DCFG1_INTR_LEN]
                ? `UVRA_INTR_LEN_LONG : `UVRA_INTR_LEN_SHORT;
        end
    end
endmodule : uvra_vendor_access

/* File: tb/uvra_access_monitor.sv */
// Purpose: Port checks on the vendor request decoder.
// Assumes: One clock; only the decoder's ports are seen.
// Notes: Register state is hidden, so answers are tied to requests.
`timescale 1ns/100ps
module uvra_access_monitor (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic setup_valid,
    input wire logic [7:0] setup_type,
    input wire logic [7:0] setup_request,
    input wire logic [15:0] setup_value,
    input wire logic [15:0] setup_index,
    input wire logic [15:0] setup_length,
    input wire logic setup_ready,
    input wire logic resp_valid,
    input wire logic resp_stall,
    input wire logic [3:0] intr_report_len,
    input wire logic ee_req,
    input wire logic [7:0] ee_addr,
    input wire logic [1:0] p_tx_load,
    input wire logic [15:0] p_tx_data,
    input wire logic [1:0] p_tick16,
    input wire logic [1:0] p_bit_tick,
    input wire logic [7:0] global_ctl_1
);
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    logic take;
    logic port_rd;
    assign take = setup_valid && setup_ready;
    // A well formed one byte read; target checked per property.
    assign port_rd = take && setup_type == 8'hC0 && setup_request == 8'h0D
        && setup_length == 16'h0001 && setup_index[7:3] == 5'h00;

    a_answer_one_cycle: assert property (resp_valid |=> !resp_valid)
        else $error("answer pulse too long");
    a_stall_with_answer: assert property (
        resp_stall |-> resp_valid && !setup_ready)
        else $error("stall without answer");
    a_bad_code_stall: assert property (take && setup_request != 8'h0D
        && setup_request != 8'h0E |=> resp_valid && resp_stall)
        else $error("unknown request code not refused");
    a_bad_length_stall: assert property (
        take && setup_length != 16'h0001 |=> resp_valid && resp_stall)
        else $error("bad length not refused");
    a_bad_offset_stall: assert property (take
        && setup_value[15:8] != 8'h09 && setup_index[7:3] != 5'h00
        |=> resp_stall)
        else $error("offset above 7 not refused");
    a_port_read_ok: assert property (port_rd && (setup_value[15:8] == 8'h01
        || setup_value[15:8] == 8'h03) |=> resp_valid && !resp_stall)
        else $error("port read refused");
    a_eeprom_launch: assert property (
        port_rd && setup_value[15:8] == 8'h09 |=> ee_req && !resp_valid
        && ee_addr == $past(setup_index[7:0]))
        else $error("eeprom access not launched");
    a_tx_data_byte: assert property (p_tx_load[0] |-> resp_valid
        && p_tx_data[7:0] == $past(setup_value[7:0]))
        else $error("holding data differs from value byte");
    a_bit_after_tick: assert property (
        p_bit_tick[0] |-> $past(p_tick16[0]))
        else $error("bit tick without oversample tick");
    a_report_length: assert property ($stable(global_ctl_1[6]) |->
        intr_report_len == (global_ctl_1[6] ? 4'hD : 4'h5))
        else $error("report length wrong");
    c_eeprom_read: cover property (port_rd && setup_value[15:8] == 8'h09);
    c_stall: cover property (resp_stall);
    c_tx_load: cover property (p_tx_load[0]);
endmodule : uvra_access_monitor

bind uvra_vendor_access uvra_access_monitor u_mon (
    .sys_clk(sys_clk), .resetn(resetn), .setup_valid(setup_valid),
    .setup_type(setup_type), .setup_request(setup_request),
    .setup_value(setup_value), .setup_index(setup_index),
    .setup_length(setup_length), .setup_ready(setup_ready),
    .resp_valid(resp_valid), .resp_stall(resp_stall),
    .intr_report_len(intr_report_len), .ee_req(ee_req),
    .ee_addr(ee_addr), .p_tx_load(p_tx_load), .p_tx_data(p_tx_data),
    .p_tick16(p_tick16), .p_bit_tick(p_bit_tick),
    .global_ctl_1(global_ctl_1)
);

/* File: tb/uvra_host_model.sv */
// Purpose: Host controller issuing vendor setup requests.
// Assumes: One request at a time, started by the bench.
// Notes: Released value and index fields carry inverted data so stale values fail.
`timescale 1ns/100ps
module uvra_host_model (
    input wire logic sys_clk,
    output logic setup_valid,
    output logic [7:0] setup_type,
    output logic [7:0] setup_request,
    output logic [15:0] setup_value,
    output logic [15:0] setup_index,
    output logic [15:0] setup_length,
    input wire logic setup_ready,
    input wire logic resp_valid,
    input wire logic resp_stall,
    input wire logic [7:0] resp_data
);
    initial setup_valid = 1'b0;

    task access(input logic [7:0] rq, input logic [15:0] val, idx, len,
            input logic bad, input int gap, output logic [7:0] rd,
            output logic st);
        int n;
        n = 0;
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        setup_valid <= 1'b1;
        setup_type <= {bad ^ (rq == 8'h0D), 7'h40};
        setup_request <= rq;
        setup_value <= val;
        setup_index <= idx;
        setup_length <= len;
        @(negedge sys_clk);
        while (!setup_ready && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        setup_valid <= 1'b0;
        setup_value <= ~val;
        setup_index <= ~idx;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (!resp_valid && n < 50);
        rd = resp_valid ? resp_data : 8'hxx;
        st = resp_valid ? resp_stall : 1'bx;
    endtask : access
endmodule : uvra_host_model

/* File: tb/tb_uvra_vendor_access.sv */
// Purpose: Self-checking bench for the vendor request decoder.
// Assumes: The host model sends requests; the bench plays UART and EEPROM.
// Notes: Divisors stay small so the run is short.
`timescale 1ns/100ps
module tb_uvra_vendor_access;
    logic sys_clk, resetn, high_speed, ee_req, ee_write, ee_done, st;
    logic s_valid, s_ready, r_valid, r_stall;
    logic [7:0] s_type, s_req, r_data, ee_addr, ee_wdata, ee_rdata, gc1;
    logic [7:0] ee_val, tx_seen, ff_seen, rd, lo, d;
    logic [15:0] s_val, s_idx, s_len, p_rx, p_iir, p_lsr, p_msr, p_tx, p_ff;
    logic [16:0] ee_seen;
    logic [9:0] ep0_sz, bulk_sz;
    logic [3:0] rep_len;
    logic [1:0] tx_act, tx_load, ff_load, rx_pop, dtr_n, tick16, bit_tick;
    logic [7:0] modes [3] = '{8'h00, 8'h80, 8'hC0};
    int seed = 1098, err_count = 0, compares = 0, cycles = 0;
    int tx_n = 0, pops = 0, ee_cnt = 0, per;

    uvra_vendor_access uut (
        .sys_clk(sys_clk), .resetn(resetn), .setup_valid(s_valid),
        .setup_type(s_type), .setup_request(s_req), .setup_value(s_val),
        .setup_index(s_idx), .setup_length(s_len), .setup_ready(s_ready),
        .resp_valid(r_valid), .resp_stall(r_stall), .resp_data(r_data),
        .high_speed(high_speed), .ep0_max_size(ep0_sz),
        .bulk_max_size(bulk_sz), .intr_report_len(rep_len),
        .ee_req(ee_req), .ee_write(ee_write), .ee_addr(ee_addr),
        .ee_wdata(ee_wdata), .ee_done(ee_done), .ee_rdata(ee_rdata),
        .p_rx_data(p_rx), .p_iir_status(p_iir), .p_lsr_status(p_lsr),
        .p_msr_status(p_msr), .p_tx_active(tx_act), .p_tx_load(tx_load),
        .p_tx_data(p_tx), .p_fifo_ctl_load(ff_load), .p_fifo_ctl(p_ff),
        .p_rx_pop(rx_pop), .p_dtr_n(dtr_n), .p_tick16(tick16),
        .p_bit_tick(bit_tick), .global_ctl_0(), .global_ctl_1(gc1)
    );
    uvra_host_model host (
        .sys_clk(sys_clk), .setup_valid(s_valid), .setup_type(s_type),
        .setup_request(s_req), .setup_value(s_val), .setup_index(s_idx),
        .setup_length(s_len), .setup_ready(s_ready), .resp_valid(r_valid),
        .resp_stall(r_stall), .resp_data(r_data)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // The EEPROM answers four cycles late.
    always @(posedge sys_clk) begin
        ee_cnt <= (ee_req && !ee_done) ? ee_cnt + 1 : 0;
        ee_done <= ee_req && !ee_done && ee_cnt == 3;
        ee_rdata <= (ee_cnt == 3) ? ee_val : ~ee_val;
        if (ee_done) ee_seen <= {ee_write, ee_addr, ee_wdata};
        if (tx_load[0]) tx_seen <= p_tx[7:0];
        if (tx_load[0]) tx_n <= tx_n + 1;
        if (ff_load[0]) ff_seen <= p_ff[7:0];
        if (rx_pop[0]) pops <= pops + 1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            give_verdict();
        end
    end

    function logic [15:0] exp_period(input logic [7:0] h, l);
        return 16'(16 * (256 * h + l));
    endfunction : exp_period

    // Modem control bit 0 is set first.
    function logic exp_dtr(input logic [7:0] scr, input logic ta);
        if (!scr[7]) return 1'b0;
        return scr[6] ? ta : !ta;
    endfunction : exp_dtr

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task xfer(input logic [7:0] rq, input logic [15:0] v, i, n,
            input logic bad);
        host.access(rq, v, i, n, bad, $random(seed) & 3, rd, st);
    endtask : xfer

    task wr(input logic [7:0] tgt, input logic [2:0] o, input logic [7:0] v);
        xfer(8'h0E, {tgt, v}, {13'h0, o}, 16'h0001, 1'b0);
        chk({15'h0, st}, 16'h0000);
    endtask : wr

    task rdc(input logic [7:0] tgt, input logic [2:0] o, input logic [7:0] v);
        xfer(8'h0D, {tgt, 8'h00}, {13'h0, o}, 16'h0001, 1'b0);
        chk({7'h00, st, rd}, {8'h00, v});
    endtask : rdc

    task stl(input logic [7:0] rq, input logic [15:0] v, i, n, input logic b);
        xfer(rq, v, i, n, b);
        chk({7'h00, st, rd}, 16'h0100);
    endtask : stl

    task bit_period(output int n);
        while (!bit_tick[0]) @(negedge sys_clk);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (!bit_tick[0] && n < 9000);
    endtask : bit_period

    task give_verdict;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        resetn = 1'b0;
        {high_speed, tx_act} = 3'h0;
        {p_rx, p_iir, p_lsr, p_msr} = {$random(seed), $random(seed)};
        ee_val = $random(seed);
        lo = 8'(($random(seed) & 7) + 1);
        d = $random(seed);
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk({6'h00, ep0_sz}, 16'h0008);
        chk({12'h000, rep_len}, 16'h0005);
        chk({14'h0, dtr_n}, 16'h0003);
        bit_period(per);
        chk(per[15:0], exp_period(8'h00, 8'h01));
        rdc(8'h01, 3'h3, 8'h00);
        wr(8'h01, 3'h3, 8'h80);
        rdc(8'h01, 3'h0, 8'h01);
        rdc(8'h01, 3'h1, 8'h00);
        wr(8'h01, 3'h0, lo);
        wr(8'h01, 3'h1, 8'h01);
        rdc(8'h01, 3'h0, lo);
        rdc(8'h01, 3'h1, 8'h01);
        bit_period(per);
        bit_period(per);
        chk(per[15:0], exp_period(8'h01, lo));
        wr(8'h01, 3'h3, 8'h03);
        wr(8'h01, 3'h0, d);
        wr(8'h01, 3'h2, ~d);
        rdc(8'h01, 3'h0, p_rx[7:0]);
        rdc(8'h01, 3'h2, p_iir[7:0]);
        rdc(8'h01, 3'h5, p_lsr[7:0]);
        rdc(8'h01, 3'h6, p_msr[7:0]);
        @(negedge sys_clk);
        chk({8'h00, tx_seen}, {8'h00, d});
        chk({8'h00, ff_seen}, {8'h00, ~d});
        chk({tx_n[7:0], pops[7:0]}, 16'h0101);
        wr(8'h01, 3'h4, 8'h01);
        for (int m = 0; m < 3; m++) begin
            wr(8'h01, 3'h7, modes[m]);
            rdc(8'h01, 3'h7, modes[m]);
            for (int t = 0; t < 2; t++) begin
                @(posedge sys_clk);
                tx_act <= {2{t[0]}};
                repeat (3) @(negedge sys_clk);
                chk({15'h0, dtr_n[0]}, {15'h0, exp_dtr(modes[m], t[0])});
            end
        end
        wr(8'h03, 3'h7, d);
        rdc(8'h03, 3'h7, d);
        rdc(8'h01, 3'h7, 8'hC0);
        wr(8'h00, 3'h1, 8'h40);
        rdc(8'h00, 3'h1, 8'h40);
        repeat (2) @(negedge sys_clk);
        chk({gc1, 4'h0, rep_len}, 16'h400D);
        for (int w = 0; w < 2; w++) begin
            xfer(w ? 8'h0E : 8'h0D, {8'h09, d}, {8'h00, lo}, 16'h0001, 1'b0);
            chk({7'h00, st, rd}, {8'h00, w ? 8'h00 : ee_val});
            chk({7'h00, ee_seen[16:8]}, {7'h00, w[0], lo});
        end
        chk({8'h00, ee_seen[7:0]}, {8'h00, d});
        stl(8'h0C, 16'h0100, 16'h0000, 16'h0001, 1'b0);
        stl(8'h0D, 16'h0100, 16'h0000, 16'h0001, 1'b1);
        stl(8'h0E, 16'h0155, 16'h0000, 16'h0002, 1'b0);
        stl(8'h0D, 16'h0500, 16'h0000, 16'h0001, 1'b0);
        stl(8'h0D, 16'h0100, 16'h0008, 16'h0001, 1'b0);
        @(posedge sys_clk);
        high_speed <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({6'h00, ep0_sz}, 16'h0040);
        chk({6'h00, bulk_sz}, 16'h0200);
        give_verdict();
    end
endmodule : tb_uvra_vendor_access
